//--- test/fivd_dispatch_test.sv
// self-checking bench for the vector dispatch block
`timescale 1ns/10ps
`include "fivd_params.svh"
module fivd_dispatch_test;
   import fivd_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   logic brk_ff = 1'b0;
   fivd_fixed_t fixed_req = '0;
   logic [29:0] mask_req = '0;
   logic [89:0] mask_level = '0;
   logic [2:0] ipl = 3'h0;
   logic int_enable = 1'b0;
   logic [19:0] reloc_base = 20'h0_1230;
   fivd_cause_t cause_clr = '0;
   logic mem_rd, mem_ack, pc_load, mask_ack, idcheck_valid, rsvd_bad;
   logic [7:0] mem_data, idcheck_byte;
   logic [19:0] mem_addr, pc_value;
   logic [4:0] mask_ack_id;
   logic [3:0] idcheck_slot;
   fivd_fixed_t fixed_ack;
   fivd_cause_t cause;
   int err_total = 0;
   int checked = 0;
   fivd_dispatch fivd_dispatch_inst (.clk, .rst_n, .fixed_req, .mask_req, .mask_level, .ipl, .int_enable,
      .reloc_base, .mem_addr, .mem_rd, .mem_ack, .mem_data, .pc_load, .pc_value, .mask_ack, .mask_ack_id,
      .fixed_ack, .cause, .cause_clr, .idcheck_valid, .idcheck_byte, .idcheck_slot, .rsvd_bad);
   fivd_vec_mem fivd_vec_mem_inst (.clk, .rst_n, .slow, .brk_ff, .mem_addr, .mem_rd, .mem_ack, .mem_data);
   initial begin
      forever #12.5 clk = ~clk;
   end
   // target built from the memory pattern, little-endian, low 20 bits
   function automatic logic [19:0] exp_pc(logic [19:0] b);
      return {4'(b + 20'h0_0002), {2{4'(b + 20'h0_0001)}}, {2{b[3:0]}}};
   endfunction
   task automatic cmp(string what, logic [19:0] exp, logic [19:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("counts: %0d checked, %0d mismatched", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // waits for pc_load (0), fixed_ack (1) or mask_ack (2)
   task automatic await(int sel);
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if (sel == 0 ? pc_load === 1'b1 : sel == 1 ? fixed_ack !== '0 : mask_ack === 1'b1) return;
      end
      err_total++;
      $display("FAIL wait %0d expected event seen none", sel);
      give_verdict();
   endtask
   task automatic t_boot();
      await(0);
      cmp("boot pc", exp_pc(`FIVD_VEC_RESET), pc_value);
      cmp("rsvd flag", 20'h0_0000, {19'h0_0000, rsvd_bad});
      $display("boot done");
   endtask
   task automatic t_fixed();
      logic [19:0] slot [10] = '{`FIVD_VEC_NMI, `FIVD_VEC_DEBUG, `FIVD_VEC_WDOG, `FIVD_VEC_WDOG, `FIVD_VEC_WDOG,
         `FIVD_VEC_STEP, `FIVD_VEC_AMATCH, `FIVD_VEC_BRK, `FIVD_VEC_OVF, `FIVD_VEC_UNDEF};
      for (int b = 0; b < 10; b++) begin
         @(posedge clk);
         fixed_req <= fivd_fixed_t'(10'h001 << b); // step and debug driven as a development tool would
         slow <= b[0];
         await(1);
         cmp("fixed ack", 20'(10'h001 << b), 20'(fixed_ack));
         @(posedge clk) fixed_req <= '0;
         await(0);
         cmp("fixed pc", exp_pc(slot[b]), pc_value);
         cmp("cause", (b > 1 && b < 5) ? 20'h0_0001 << (b - 2) : 20'h0_0000, 20'(cause));
         @(posedge clk) cause_clr <= '1;
         @(posedge clk) cause_clr <= '0;
      end
      $display("fixed slots done");
   endtask
   task automatic t_brk_reloc();
      @(posedge clk);
      brk_ff <= 1'b1;
      fixed_req <= fivd_fixed_t'(10'h080);
      await(1);
      @(posedge clk) fixed_req <= '0;
      await(0);
      cmp("reloc pc", exp_pc(reloc_base), pc_value);
      @(posedge clk) brk_ff <= 1'b0;
      $display("breakpoint relocation done");
   endtask
   task automatic t_mask();
      @(posedge clk);
      int_enable <= 1'b1;
      ipl <= 3'h1;
      mask_level[89:87] <= 3'h6;
      mask_level[17:15] <= 3'h2;
      mask_req <= 30'h2000_0020;
      await(2);
      cmp("mask id", 20'h0_001D, 20'(mask_ack_id));
      @(posedge clk) mask_req <= 30'h0000_0020;
      await(0);
      cmp("mask pc", exp_pc(reloc_base + 20'h0_0074), pc_value);
      await(2);
      cmp("mask id", 20'h0_0005, 20'(mask_ack_id));
      @(posedge clk) mask_req <= '0;
      await(0);
      cmp("mask pc", exp_pc(reloc_base + 20'h0_0014), pc_value);
      $display("maskable done");
   endtask
   // second reset in mid-run, with the memory showing a bad reserved nibble
   task automatic t_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      brk_ff <= 1'b1;
      repeat (2) @(posedge clk);
      cmp("reset clear", 20'h0_0000, pc_value);
      rst_n <= 1'b1;
      await(0);
      cmp("reset pc", exp_pc(`FIVD_VEC_RESET), pc_value);
      cmp("rsvd flag", 20'h0_0001, {19'h0_0000, rsvd_bad});
      @(posedge clk) brk_ff <= 1'b0;
      $display("mid-run reset done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_boot();
      t_fixed();
      t_brk_reloc();
      t_mask();
      t_reset();
      give_verdict();
   end
endmodule

//--- test/fivd_props.sv
// checker for the vector dispatch block
`timescale 1ns/10ps
`include "fivd_params.svh"
module fivd_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire fivd_pkg::fivd_fixed_t fixed_ack,
   input wire fivd_pkg::fivd_cause_t cause,
   input wire fivd_pkg::fivd_cause_t cause_clr,
   input wire logic [19:0] reloc_base,
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_ack,
   input wire logic [7:0] mem_data,
   input wire logic pc_load,
   input wire logic [19:0] pc_value,
   input wire logic idcheck_valid,
   input wire logic [7:0] idcheck_byte,
   input wire logic [3:0] idcheck_slot,
   input wire logic rsvd_bad
);
   import fivd_pkg::*;
   logic [31:0] sh_q;
   logic [31:0] sh_d;
   logic [2:0] keep_q;
   logic [2:0] keep_d;
   // fetched bytes shift in from the top, so the lowest address ends lowest
   always_comb begin
      sh_d = sh_q;
      keep_d = cause & ~cause_clr; // flags set and not being cleared
      if (mem_rd && mem_ack) begin
         sh_d = {mem_data, sh_q[31:8]};
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 32'h0000_0000;
         keep_q <= 3'h0;
      end else begin
         sh_q <= sh_d;
         keep_q <= keep_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_byte;
      mem_rd && mem_ack;
   endsequence
   sequence s_brk_mark;
      s_byte ##0 mem_addr == `FIVD_VEC_BRK + 20'h0_0003 && mem_data == `FIVD_BRK_RELOC_MARK;
   endsequence
   chk_slot_addr: assert property (fixed_ack != '0 |-> mem_rd && mem_addr >= `FIVD_VEC_BASE && mem_addr[1:0] == 2'h0)
      else $error("fixed fetch off a slot start");
   chk_byte_step: assert property (s_byte ##0 mem_addr[1:0] != 2'h3 |=> mem_rd && mem_addr == $past(mem_addr) + 20'h0_0001)
      else $error("vector bytes not consecutive");
   chk_pc_target: assert property (pc_load |-> pc_value == sh_q[19:0])
      else $error("pc differs from fetched vector");
   chk_pc_once: assert property (pc_load |=> !pc_load [*4])
      else $error("pc load not a single pulse");
   chk_reloc_jump: assert property (s_brk_mark |-> ##[1:4] mem_rd && mem_addr == reloc_base)
      else $error("relocation mark not followed");
   chk_idcheck_byte: assert property (idcheck_valid && idcheck_slot != 4'h2 |-> idcheck_byte == sh_q[31:24])
      else $error("id check byte wrong");
   chk_rsvd_flag: assert property (idcheck_valid && idcheck_slot == 4'h8 |-> ##2 rsvd_bad == (($past(idcheck_byte, 2) & 8'h0F) != 8'h0F))
      else $error("reserved bits flag wrong");
   chk_cause_hold: assert property ((keep_q & ~cause) == 3'h0)
      else $error("cause flag lost without clear");
endmodule
bind fivd_dispatch fivd_props fivd_props_inst (.clk, .rst_n, .fixed_ack, .cause, .cause_clr, .reloc_base,
   .mem_addr, .mem_rd, .mem_ack, .mem_data, .pc_load, .pc_value, .idcheck_valid, .idcheck_byte,
   .idcheck_slot, .rsvd_bad);

//--- test/fivd_vec_mem.sv
// program memory model answering vector byte reads
`timescale 1ns/10ps
module fivd_vec_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic brk_ff,
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   output logic mem_ack,
   output logic [7:0] mem_data
);
   logic [1:0] wait_q;
   logic [7:0] last_q;
   // with brk_ff low, byte is the low address nibble twice; reset top byte is FF, keeping bits 3..0 at 1111
   function automatic logic [7:0] byte_at(logic [19:0] a, logic f);
      if (f && a == 20'hF_FFE7) return 8'hFF;
      if (f && a == 20'hF_FFFF) return 8'hF0; // reserved bits broken on purpose
      return {a[3:0], a[3:0]};
   endfunction
   // one or three wait cycles; data is scrambled whenever no byte is offered
   assign mem_ack = mem_rd && wait_q == (slow ? 2'h3 : 2'h1);
   assign mem_data = mem_ack ? byte_at(mem_addr, brk_ff) : ~last_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 2'h0;
         last_q <= 8'h00;
      end else begin
         wait_q <= (mem_rd && !mem_ack) ? wait_q + 2'h1 : 2'h0;
         last_q <= mem_data;
      end
   end
endmodule

//--- verilog/fivd_dispatch.sv
// fixed interrupt vector dispatch: picks a slot, fetches its four bytes, loads the pc
`timescale 1ns/10ps
`include "fivd_params.svh"
module fivd_dispatch #(
   parameter int N_ONCHIP = 18,
   parameter int N_EXT = 8,
   parameter int N_SOFT = 4
) (
   clk,
   rst_n,
   fixed_req,
   mask_req,
   mask_level,
   ipl,
   int_enable,
   reloc_base,
   mem_addr,
   mem_rd,
   mem_ack,
   mem_data,
   pc_load,
   pc_value,
   mask_ack,
   mask_ack_id,
   fixed_ack,
   cause,
   cause_clr,
   idcheck_valid,
   idcheck_byte,
   idcheck_slot,
   rsvd_bad
);
   import fivd_pkg::*;
   localparam int N_MASK = N_ONCHIP + N_EXT + N_SOFT;
   localparam int IDW = $clog2(N_MASK);
   input wire logic clk;
   input wire logic rst_n;
   input wire fivd_pkg::fivd_fixed_t fixed_req; // level requests, held until fixed_ack
   input wire logic [N_MASK-1:0] mask_req;
   input wire logic [N_MASK*3-1:0] mask_level;
   input wire logic [2:0] ipl;
   input wire logic int_enable;
   input wire logic [19:0] reloc_base;
   output logic [19:0] mem_addr;
   output logic mem_rd;
   input wire logic mem_ack;
   input wire logic [7:0] mem_data;
   output logic pc_load;
   output logic [19:0] pc_value;
   output logic mask_ack;
   output logic [IDW-1:0] mask_ack_id;
   output fivd_pkg::fivd_fixed_t fixed_ack;
   output fivd_pkg::fivd_cause_t cause;
   input wire fivd_pkg::fivd_cause_t cause_clr;
   output logic idcheck_valid;
   output logic [7:0] idcheck_byte;
   output logic [3:0] idcheck_slot;
   output logic rsvd_bad;

   // refuse source counts that the arbiter and the id width were not built for
   if (N_ONCHIP != 18 || N_EXT != 8 || N_SOFT != 4) begin : g_bad_counts
      $error("source counts must be 18, 8 and 4");
   end

   // ----------------------------------------
   // maskable arbitration
   // ----------------------------------------
   // highest level wins, lowest index on a tie; level 0 means disabled
   logic [2:0] best_lvl;
   logic [IDW-1:0] best_id;
   logic best_hit;
   always_comb begin
      best_lvl = 3'h0;
      best_id = '0;
      best_hit = 1'b0;
      for (int i = 0; i < N_MASK; i++) begin
         if (mask_req[i] && mask_level[i*3 +: 3] > best_lvl) begin
            best_lvl = mask_level[i*3 +: 3];
            best_id = IDW'(i);
            best_hit = 1'b1;
         end
      end
   end
   logic mask_win;
   assign mask_win = best_hit && int_enable && (best_lvl > ipl);

   // ----------------------------------------
   // fixed slot selection
   // ----------------------------------------
   // priority: reset, nmi, debug, watchdog group, step, match, traps
   logic [19:0] slot_sel;
   logic sel_fixed;
   fivd_fixed_t ack_sel;
   always_comb begin
      slot_sel = `FIVD_VEC_UNDEF;
      sel_fixed = 1'b1;
      ack_sel = '0;
      if (fixed_req.nmi) begin
         slot_sel = `FIVD_VEC_NMI;
         ack_sel.nmi = 1'b1;
      end else if (fixed_req.debug) begin
         slot_sel = `FIVD_VEC_DEBUG;
         ack_sel.debug = 1'b1;
      end else if (fixed_req.wdog || fixed_req.osc || fixed_req.vdrop) begin
         slot_sel = `FIVD_VEC_WDOG;
         ack_sel.wdog = fixed_req.wdog;
         ack_sel.osc = fixed_req.osc;
         ack_sel.vdrop = fixed_req.vdrop;
      end else if (fixed_req.step) begin
         slot_sel = `FIVD_VEC_STEP;
         ack_sel.step = 1'b1;
      end else if (fixed_req.amatch) begin
         slot_sel = `FIVD_VEC_AMATCH;
         ack_sel.amatch = 1'b1;
      end else if (fixed_req.breakpoint_opcode) begin
         slot_sel = `FIVD_VEC_BRK;
         ack_sel.breakpoint_opcode = 1'b1;
      end else if (fixed_req.ovf_trap) begin
         slot_sel = `FIVD_VEC_OVF;
         ack_sel.ovf_trap = 1'b1;
      end else if (fixed_req.undef_trap) begin
         slot_sel = `FIVD_VEC_UNDEF;
         ack_sel.undef_trap = 1'b1;
      end else begin
         sel_fixed = 1'b0;
      end
   end

   // ----------------------------------------
   // fetch sequencer
   // ----------------------------------------
   fivd_state_t state_q, state_d;
   logic [19:0] base_q, base_d;
   logic [1:0] idx_q, idx_d;
   logic [31:0] acc_q, acc_d;
   logic boot_q, boot_d;
   logic brk_q, brk_d;
   logic pcl_q, pcl_d;
   logic [19:0] pcv_q, pcv_d;
   logic mack_q, mack_d;
   logic [IDW-1:0] mid_q, mid_d;
   fivd_fixed_t fack_q, fack_d;
   fivd_cause_t cause_q, cause_d;
   logic idv_q, idv_d;
   logic [7:0] idb_q, idb_d;
   logic [3:0] ids_q, ids_d;
   logic rsvd_q, rsvd_d;
   // next-state for the sequencer and its outputs
   always_comb begin
      state_d = state_q;
      base_d = base_q;
      idx_d = idx_q;
      acc_d = acc_q;
      boot_d = boot_q;
      brk_d = brk_q;
      pcl_d = 1'b0;
      pcv_d = pcv_q;
      mack_d = 1'b0;
      mid_d = mid_q;
      fack_d = '0;
      idv_d = 1'b0;
      idb_d = idb_q;
      ids_d = ids_q;
      rsvd_d = rsvd_q;
      // set wins over clear for the shared-slot cause flags
      cause_d = cause_q & ~cause_clr;
      unique case (state_q)
         ST_IDLE: begin
            if (boot_q) begin
               base_d = `FIVD_VEC_RESET;
               boot_d = 1'b0;
               brk_d = 1'b0;
               idx_d = 2'h0;
               state_d = ST_REQ;
            end else if (sel_fixed) begin
               base_d = slot_sel;
               brk_d = ack_sel.breakpoint_opcode;
               fack_d = ack_sel;
               cause_d = cause_d | {ack_sel.wdog, ack_sel.osc, ack_sel.vdrop};
               idx_d = 2'h0;
               state_d = ST_REQ;
            end else if (mask_win) begin
               base_d = reloc_base + 20'({best_id, 2'h0});
               brk_d = 1'b0;
               mack_d = 1'b1;
               mid_d = best_id;
               idx_d = 2'h0;
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (mem_ack) begin
               // little-endian assembly, lowest address first
               acc_d = {mem_data, acc_q[31:8]};
               if (idx_q == 2'h3) begin
                  state_d = ST_JUMP;
                  if (base_q >= `FIVD_VEC_BASE) begin
                     idv_d = 1'b1;
                     idb_d = mem_data;
                     ids_d = 4'((base_q - `FIVD_VEC_BASE) >> 2);
                  end
                  if (base_q == `FIVD_VEC_RESET) begin
                     rsvd_d = mem_data[3:0] != `FIVD_RESET_RSVD;
                  end
                  if (brk_q && mem_data == `FIVD_BRK_RELOC_MARK) begin
                     state_d = ST_RELOC;
                  end
               end else begin
                  idx_d = idx_q + 2'h1;
                  state_d = ST_REQ;
               end
            end
         end
         ST_JUMP: begin
            pcl_d = 1'b1;
            pcv_d = acc_q[19:0];
            state_d = ST_IDLE;
         end
         ST_RELOC: begin
            // breakpoint entry of the relocatable table is its first slot
            base_d = reloc_base;
            brk_d = 1'b0;
            idx_d = 2'h0;
            state_d = ST_REQ;
         end
      endcase
   end

   // registers of the sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         base_q <= 20'h0_0000;
         idx_q <= 2'h0;
         acc_q <= 32'h0000_0000;
         boot_q <= 1'b1;
         brk_q <= 1'b0;
         pcl_q <= 1'b0;
         pcv_q <= 20'h0_0000;
         mack_q <= 1'b0;
         mid_q <= '0;
         fack_q <= '0;
         cause_q <= '0;
         idv_q <= 1'b0;
         idb_q <= 8'h00;
         ids_q <= 4'h0;
         rsvd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         base_q <= base_d;
         idx_q <= idx_d;
         acc_q <= acc_d;
         boot_q <= boot_d;
         brk_q <= brk_d;
         pcl_q <= pcl_d;
         pcv_q <= pcv_d;
         mack_q <= mack_d;
         mid_q <= mid_d;
         fack_q <= fack_d;
         cause_q <= cause_d;
         idv_q <= idv_d;
         idb_q <= idb_d;
         ids_q <= ids_d;
         rsvd_q <= rsvd_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign mem_rd = (state_q == ST_REQ) || (state_q == ST_WAIT);
   assign mem_addr = base_q + {18'h0, idx_q};
   assign pc_load = pcl_q;
   assign pc_value = pcv_q;
   assign mask_ack = mack_q;
   assign mask_ack_id = mid_q;
   assign fixed_ack = fack_q;
   assign cause = cause_q;
   assign idcheck_valid = idv_q;
   assign idcheck_byte = idb_q;
   assign idcheck_slot = ids_q;
   assign rsvd_bad = rsvd_q;
endmodule

//--- verilog/fivd_params.svh
// constants of the fixed interrupt vector dispatch block
`ifndef FIVD_PARAMS_SVH
`define FIVD_PARAMS_SVH
// ----------------------------------------
// vector slot base addresses
// ----------------------------------------
`define FIVD_VEC_BASE 20'hF_FFDC
`define FIVD_VEC_UNDEF 20'hF_FFDC
`define FIVD_VEC_OVF 20'hF_FFE0
`define FIVD_VEC_BRK 20'hF_FFE4
`define FIVD_VEC_AMATCH 20'hF_FFE8
`define FIVD_VEC_STEP 20'hF_FFEC
`define FIVD_VEC_WDOG 20'hF_FFF0
`define FIVD_VEC_DEBUG 20'hF_FFF4
`define FIVD_VEC_NMI 20'hF_FFF8
`define FIVD_VEC_RESET 20'hF_FFFC
// ----------------------------------------
// misc values
// ----------------------------------------
`define FIVD_SLOT_BYTES 3'h4
`define FIVD_BRK_RELOC_MARK 8'hFF
`define FIVD_RESET_RSVD 4'hF
`define FIVD_CAUSE_RST 3'h0
`endif

//--- verilog/fivd_pkg.sv
// types of the fixed interrupt vector dispatch block
package fivd_pkg;
   // fixed sources, one bit each
   typedef struct packed {
      logic undef_trap;
      logic ovf_trap;
      logic breakpoint_opcode;
      logic amatch;
      logic step;
      logic wdog;
      logic osc;
      logic vdrop;
      logic debug;
      logic nmi;
   } fivd_fixed_t;
   // shared-slot cause flags
   typedef struct packed {
      logic wdog;
      logic osc;
      logic vdrop;
   } fivd_cause_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_REQ = 5'b0_0010,
      ST_WAIT = 5'b0_0100,
      ST_JUMP = 5'b0_1000,
      ST_RELOC = 5'b1_0000
   } fivd_state_t;
endpackage
